// ==== bench/twm_pin_model.sv ====
`timescale 1ns/1ps
module twm_pin_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Driver from the block
    input wire logic pin_out,
    input wire logic pin_oe,
    // Level seen on the pad
    output logic pad
);
    logic last_q;

    // Last driven level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'h0;
        end else if (pin_oe) begin
            last_q <= pin_out;
        end
    end
    // No pull on the pad, so a released pin shows the inverse of its last level
    assign pad = pin_oe ? pin_out : ~last_q;
endmodule : twm_pin_model

// ==== bench/twm_timer_top_asserts.sv ====
`timescale 1ns/1ps
module twm_timer_top_asserts (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Port side and pins
    input wire logic DIR_A,
    input wire logic DIR_B,
    input wire logic PORT_A,
    input wire logic PORT_B,
    input wire logic PIN_A_OUT,
    input wire logic PIN_A_OE,
    input wire logic PIN_B_OUT,
    input wire logic PIN_B_OE,
    // Interrupt
    input wire logic IRQ
);
    logic [7:0] ca_q;
    logic [7:0] ca_d;
    logic [2:0] en_q;
    logic [2:0] en_d;
    logic acc_wr;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // Shadow of control A and interrupt enable, taken from completed writes
    assign acc_wr = PSEL && PENABLE && PREADY && PWRITE;
    always_comb begin
        ca_d = ca_q;
        en_d = en_q;
        if (acc_wr && PADDR == twm_pkg::OFF_CTRL_A) begin
            ca_d = PWDATA[7:0] & 8'hF3;
        end
        if (acc_wr && PADDR == twm_pkg::OFF_INT_EN) begin
            en_d = PWDATA[2:0];
        end
    end
    // Shadow registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ca_q <= 8'h00;
            en_q <= 3'h0;
        end else begin
            ca_q <= ca_d;
            en_q <= en_d;
        end
    end

    // Bus phases
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_rd(logic [7:0] a);
        s_setup ##1 (PSEL && PENABLE && !PWRITE && PADDR == a);
    endsequence

    property p_ready;
        s_setup |=> PREADY;
    endproperty
    property p_rd_ca;
        s_rd(twm_pkg::OFF_CTRL_A) |-> PRDATA == {24'h000000, ca_q} && !PSLVERR;
    endproperty
    property p_unmap;
        s_setup ##1 (PSEL && PENABLE && !PWRITE && PADDR > twm_pkg::OFF_INT_EN) |-> PSLVERR && PRDATA == 32'h0;
    endproperty
    property p_oe;
        RST_N |=> PIN_A_OE == $past(DIR_A) && PIN_B_OE == $past(DIR_B);
    endproperty
    property p_port_a;
        ca_q[7:6] == 2'h0 |=> PIN_A_OUT == $past(PORT_A);
    endproperty
    property p_port_b;
        ca_q[5:4] == 2'h0 |=> PIN_B_OUT == $past(PORT_B);
    endproperty
    property p_irq;
        en_q == 3'h0 && $past(en_q) == 3'h0 |-> !IRQ;
    endproperty
    property p_rsvd;
        s_rd(twm_pkg::OFF_CTRL_A) |-> PRDATA[3:2] == 2'h0;
    endproperty

    a_ready: assert property (p_ready) else $error("access phase without ready");
    a_rd_ca: assert property (p_rd_ca) else $error("control A read differs");
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    a_oe: assert property (p_oe) else $error("pin enable not following direction");
    a_port_a: assert property (p_port_a) else $error("pin A not under port control");
    a_port_b: assert property (p_port_b) else $error("pin B not under port control");
    a_irq: assert property (p_irq) else $error("interrupt while all disabled");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
endmodule : twm_timer_top_asserts

bind twm_timer_top twm_timer_top_asserts twm_timer_top_asserts_inst (.CLK_SYS, .RST_N, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .DIR_A, .DIR_B, .PORT_A, .PORT_B, .PIN_A_OUT,
    .PIN_A_OE, .PIN_B_OUT, .PIN_B_OE, .IRQ);

// ==== bench/twm_timer_top_tb.sv ====
`timescale 1ns/1ps
module twm_timer_top_tb;
    localparam logic [7:0] CA = twm_pkg::OFF_CTRL_A;
    localparam logic [7:0] CB = twm_pkg::OFF_CTRL_B;
    localparam logic [7:0] CMA = twm_pkg::OFF_CMP_A;
    localparam logic [7:0] CNT = twm_pkg::OFF_COUNT;
    localparam logic [7:0] IST = twm_pkg::OFF_INT_STAT;
    localparam logic [7:0] ICL = twm_pkg::OFF_INT_CLR;
    localparam logic [7:0] IEN = twm_pkg::OFF_INT_EN;
    logic CLK_SYS = 1'h0, RST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic TIMER_TICK = 1'h0, DIR_A = 1'h0, DIR_B = 1'h0, PORT_A = 1'h0, PORT_B = 1'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, PIN_A_OUT, PIN_A_OE, PIN_B_OUT, PIN_B_OE, IRQ, pad_a, pad_b, err;
    logic [31:0] rd;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;

    // Clock
    initial begin
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    twm_timer_top twm_timer_top_inst (.CLK_SYS, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .TIMER_TICK, .DIR_A, .DIR_B, .PORT_A, .PORT_B, .PIN_A_OUT, .PIN_A_OE,
        .PIN_B_OUT, .PIN_B_OE, .IRQ);
    twm_pin_model twm_pin_model_inst (.clk(CLK_SYS), .rst_n(RST_N), .pin_out(PIN_A_OUT), .pin_oe(PIN_A_OE),
        .pad(pad_a));
    twm_pin_model twm_pin_model_b (.clk(CLK_SYS), .rst_n(RST_N), .pin_out(PIN_B_OUT), .pin_oe(PIN_B_OE),
        .pad(pad_b));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One transfer, request held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'h1;
        // Only the hang guard ends a wait that never sees ready
        do begin
            @(posedge CLK_SYS);
        end while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask : rdr

    // One count step; the negedge lets the step land
    task automatic tick();
        @(posedge CLK_SYS);
        TIMER_TICK <= 1'h1;
        @(posedge CLK_SYS);
        TIMER_TICK <= 1'h0;
        @(negedge CLK_SYS);
    endtask : tick

    // Load the count, then step once
    task automatic step(input logic [15:0] c);
        wr(CNT, {16'h0, c});
        tick();
    endtask : step

    task automatic settle();
        repeat (2) @(negedge CLK_SYS);
    endtask : settle

    // Reset value, reserved bits, unmapped place
    task automatic t_regs();
        rdr(CA);
        chk(rd, 32'h0);
        wr(CA, 32'hFFFF_FFFF);
        rdr(CA);
        chk(rd, 32'hF3);
        wr(CA, 32'h2);
        rdr(CA);
        chk(rd, 32'h2);
        wr(8'h24, 32'h1);
        chk(err, 32'h1);
        rdr(8'h24);
        chk(rd, 32'h0);
    endtask : t_regs

    // Port control and driver enable
    task automatic t_pins();
        wr(CA, 32'h0);
        PORT_A <= 1'h1;
        DIR_A <= 1'h1;
        DIR_B <= 1'h1;
        settle();
        chk(pad_a, 32'h1);
        chk(PIN_B_OE, 32'h1);
        @(posedge CLK_SYS);
        DIR_A <= 1'h0;
        settle();
        chk(PIN_A_OE, 32'h0);
        @(posedge CLK_SYS);
        DIR_A <= 1'h1;
    endtask : t_pins

    // Normal mode match actions and the interrupt
    task automatic t_match();
        logic [1:0] f [3] = '{2'h2, 2'h3, 2'h1};
        logic e [3] = '{1'h0, 1'h1, 1'h0};
        wr(CMA, 32'h2);
        wr(CNT, 32'h0);
        wr(IEN, 32'h2);
        wr(CA, 32'h40);
        tick();
        tick();
        chk(pad_a, 32'h0);
        tick();
        chk(pad_a, 32'h1);
        chk(IRQ, 32'h1);
        wr(ICL, 32'h7);
        settle();
        chk(IRQ, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(CA, {24'h0, f[i], 6'h00});
            step(16'h2);
            chk(pad_a, e[i]);
        end
        wr(IEN, 32'h0);
        settle();
        chk(IRQ, 32'h0);
    endtask : t_match

    // Fast PWM 8-bit
    task automatic t_fast();
        wr(CA, 32'hC1);
        wr(CB, 32'h1);
        wr(ICL, 32'h7);
        step(16'h2);
        chk(pad_a, 32'h1);
        rdr(IST);
        chk(rd[0], 32'h0);
        step(16'hFF);
        chk(pad_a, 32'h0);
        rdr(IST);
        chk(rd[0], 32'h1);
        wr(CMA, 32'hFF);
        step(16'hFF);
        wr(CA, 32'h81);
        step(16'hFF);
        chk(pad_a, 32'h1);
        wr(CA, 32'h51);
        PORT_A <= 1'h0;
        PORT_B <= 1'h1;
        settle();
        chk(pad_a, 32'h0);
        chk(PIN_B_OUT, 32'h1);
        chk(pad_b, 32'h1);
    endtask : t_fast

    // Dual-slope 8-bit: count direction picks the action
    task automatic t_dual();
        wr(CB, 32'h0);
        wr(CA, 32'h81);
        wr(CMA, 32'h2);
        step(16'hFF);
        chk(pad_a, 32'h0);
        step(16'h2);
        chk(pad_a, 32'h1);
        wr(ICL, 32'h7);
        step(16'h0);
        rdr(IST);
        chk(rd[0], 32'h1);
        step(16'h2);
        chk(pad_a, 32'h0);
        wr(CA, 32'h41);
        PORT_A <= 1'h1;
        settle();
        chk(pad_a, 32'h1);
    endtask : t_dual

    // Reserved mode holds, normal mode wraps at MAX
    task automatic t_modes();
        wr(CB, 32'h3);
        step(16'h5);
        rdr(CNT);
        chk(rd, 32'h5);
        wr(CB, 32'h0);
        wr(CA, 32'h0);
        wr(ICL, 32'h7);
        step(16'hFFFF);
        rdr(CNT);
        chk(rd, 32'h0);
        rdr(IST);
        chk(rd[0], 32'h1);
    endtask : t_modes

    // TOP from compare A: unit A toggles in modes 15 and 11
    task automatic t_top();
        wr(CA, 32'h43);
        wr(CB, 32'h3);
        step(16'h2);
        chk(pad_a, 32'h1);
        step(16'h2);
        chk(pad_a, 32'h0);
        wr(CB, 32'h2);
        step(16'h2);
        chk(pad_a, 32'h1);
        wr(ICL, 32'h7);
        step(16'h0);
        rdr(IST);
        chk(rd[0], 32'h1);
    endtask : t_top

    // Mid-run reset brings control A back to zero
    task automatic t_reset();
        @(posedge CLK_SYS);
        RST_N <= 1'h0;
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'h1;
        @(posedge CLK_SYS);
        rdr(CA);
        chk(rd, 32'h0);
        chk(PIN_A_OE, 32'h1);
    endtask : t_reset

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        repeat (12) @(posedge CLK_SYS);
        RST_N <= 1'h1;
        @(posedge CLK_SYS);
        t_regs();
        t_pins();
        t_match();
        t_fast();
        t_dual();
        t_modes();
        t_top();
        t_reset();
        summarize();
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
endmodule : twm_timer_top_tb

// ==== design/twm_pkg.sv ====
package twm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_CMP_A = 8'h08;
    localparam logic [7:0] OFF_CMP_B = 8'h0C;
    localparam logic [7:0] OFF_CAPT = 8'h10;
    localparam logic [7:0] OFF_COUNT = 8'h14;
    localparam logic [7:0] OFF_INT_STAT = 8'h18;
    localparam logic [7:0] OFF_INT_CLR = 8'h1C;
    localparam logic [7:0] OFF_INT_EN = 8'h20;

    // Reset values and write masks
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
    localparam logic [1:0] CTRL_B_RESET = 2'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [2:0] INT_RESET = 3'h0;

    // Counter limits
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    localparam logic [15:0] BOTTOM = 16'h0000;

    // Interrupt bit positions
    localparam int INT_OVF = 0;
    localparam int INT_MATCH_A = 1;
    localparam int INT_MATCH_B = 2;

    // Control register A layout
    typedef struct packed {
        logic [1:0] out_a_behaviour_field;
        logic [1:0] out_b_behaviour_field;
        logic [1:0] reserved;
        logic [1:0] waveform_mode_low;
    } twm_ctrl_a_t;

    // Counting families
    typedef enum logic [5:0] {
        K_NORMAL = 6'h01,
        K_CTC = 6'h02,
        K_PC = 6'h04,
        K_PFC = 6'h08,
        K_FAST = 6'h10,
        K_RSVD = 6'h20
    } twm_kind_t;

    // Where TOP comes from
    typedef enum logic [2:0] {
        TS_FIXED = 3'h1,
        TS_CMP_A = 3'h2,
        TS_CAPT = 3'h4
    } twm_top_src_t;

    // Points in the count sequence
    typedef enum logic [3:0] {
        PT_IMM = 4'h1,
        PT_TOP = 4'h2,
        PT_BOTTOM = 4'h4,
        PT_MAX = 4'h8
    } twm_point_t;

    // Decoded waveform mode
    typedef struct packed {
        twm_kind_t kind;
        twm_top_src_t top_src;
        logic [15:0] fixed_top;
        twm_point_t upd;
        twm_point_t ovf;
    } twm_mode_t;

endpackage : twm_pkg

// ==== design/twm_timer_top.sv ====
`timescale 1ns/1ps
module twm_timer_top (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Timer clock enable
    input wire logic TIMER_TICK,
    // Port side of the two pins
    input wire logic DIR_A,
    input wire logic DIR_B,
    input wire logic PORT_A,
    input wire logic PORT_B,
    // Pin drivers
    output logic PIN_A_OUT,
    output logic PIN_A_OE,
    output logic PIN_B_OUT,
    output logic PIN_B_OE,
    // Interrupt
    output logic IRQ
);

    // Mode table
    function automatic twm_pkg::twm_mode_t decode_mode(input logic [3:0] wm);
        twm_pkg::twm_mode_t m;
        m = '{twm_pkg::K_NORMAL, twm_pkg::TS_FIXED, twm_pkg::TOP_MAX, twm_pkg::PT_IMM, twm_pkg::PT_MAX};
        unique case (wm)
            4'h0: begin
                m = '{twm_pkg::K_NORMAL, twm_pkg::TS_FIXED, twm_pkg::TOP_MAX, twm_pkg::PT_IMM, twm_pkg::PT_MAX};
            end
            4'h1: begin
                m = '{twm_pkg::K_PC, twm_pkg::TS_FIXED, twm_pkg::TOP_8, twm_pkg::PT_TOP, twm_pkg::PT_BOTTOM};
            end
            4'h2: begin
                m = '{twm_pkg::K_PC, twm_pkg::TS_FIXED, twm_pkg::TOP_9, twm_pkg::PT_TOP, twm_pkg::PT_BOTTOM};
            end
            4'h3: begin
                m = '{twm_pkg::K_PC, twm_pkg::TS_FIXED, twm_pkg::TOP_10, twm_pkg::PT_TOP, twm_pkg::PT_BOTTOM};
            end
            4'h4: begin
                m = '{twm_pkg::K_CTC, twm_pkg::TS_CMP_A, twm_pkg::TOP_MAX, twm_pkg::PT_IMM, twm_pkg::PT_MAX};
            end
            4'h5: begin
                m = '{twm_pkg::K_FAST, twm_pkg::TS_FIXED, twm_pkg::TOP_8, twm_pkg::PT_TOP, twm_pkg::PT_TOP};
            end
            4'h6: begin
                m = '{twm_pkg::K_FAST, twm_pkg::TS_FIXED, twm_pkg::TOP_9, twm_pkg::PT_TOP, twm_pkg::PT_TOP};
            end
            4'h7: begin
                m = '{twm_pkg::K_FAST, twm_pkg::TS_FIXED, twm_pkg::TOP_10, twm_pkg::PT_TOP, twm_pkg::PT_TOP};
            end
            4'h8: begin
                m = '{twm_pkg::K_PFC, twm_pkg::TS_CAPT, twm_pkg::TOP_MAX, twm_pkg::PT_BOTTOM, twm_pkg::PT_BOTTOM};
            end
            4'h9: begin
                m = '{twm_pkg::K_PFC, twm_pkg::TS_CMP_A, twm_pkg::TOP_MAX, twm_pkg::PT_BOTTOM, twm_pkg::PT_BOTTOM};
            end
            4'hA: begin
                m = '{twm_pkg::K_PC, twm_pkg::TS_CAPT, twm_pkg::TOP_MAX, twm_pkg::PT_TOP, twm_pkg::PT_BOTTOM};
            end
            4'hB: begin
                m = '{twm_pkg::K_PC, twm_pkg::TS_CMP_A, twm_pkg::TOP_MAX, twm_pkg::PT_TOP, twm_pkg::PT_BOTTOM};
            end
            4'hC: begin
                m = '{twm_pkg::K_CTC, twm_pkg::TS_CAPT, twm_pkg::TOP_MAX, twm_pkg::PT_IMM, twm_pkg::PT_MAX};
            end
            4'hD: begin
                m = '{twm_pkg::K_RSVD, twm_pkg::TS_FIXED, twm_pkg::TOP_MAX, twm_pkg::PT_IMM, twm_pkg::PT_MAX};
            end
            4'hE: begin
                m = '{twm_pkg::K_FAST, twm_pkg::TS_CAPT, twm_pkg::TOP_MAX, twm_pkg::PT_TOP, twm_pkg::PT_TOP};
            end
            4'hF: begin
                m = '{twm_pkg::K_FAST, twm_pkg::TS_CMP_A, twm_pkg::TOP_MAX, twm_pkg::PT_TOP, twm_pkg::PT_TOP};
            end
        endcase
        return m;
    endfunction : decode_mode

    // One output unit: returns {connected, next wave value}
    function automatic logic [1:0] wave_step(
        input logic [1:0] f,
        input twm_pkg::twm_kind_t k,
        input logic tog_ok,
        input logic hit,
        input logic top_ev,
        input logic cmp_is_top,
        input logic down,
        input logic cur
    );
        logic c;
        logic v;
        c = (f != 2'b00);
        v = cur;
        if (k == twm_pkg::K_FAST) begin
            if (f == 2'b01) begin
                c = tog_ok;
                if (c && hit) begin
                    v = ~cur;
                end
            end else if (f[1]) begin
                if (top_ev) begin
                    v = ~f[0];
                end else if (hit && !cmp_is_top) begin
                    v = f[0];
                end
            end
        end else if (k == twm_pkg::K_PC || k == twm_pkg::K_PFC) begin
            if (f == 2'b01) begin
                c = tog_ok;
                if (c && hit) begin
                    v = ~cur;
                end
            end else if (f[1] && hit) begin
                v = down ? ~f[0] : f[0];
            end
        end else if (k != twm_pkg::K_RSVD && f != 2'b00 && hit) begin
            v = (f == 2'b01) ? ~cur : f[0];
        end
        return {c, v};
    endfunction : wave_step

    // Mapped register offsets
    function automatic logic addr_mapped(input logic [7:0] a);
        return a == twm_pkg::OFF_CTRL_A || a == twm_pkg::OFF_CTRL_B || a == twm_pkg::OFF_CMP_A
            || a == twm_pkg::OFF_CMP_B || a == twm_pkg::OFF_CAPT || a == twm_pkg::OFF_COUNT
            || a == twm_pkg::OFF_INT_STAT || a == twm_pkg::OFF_INT_CLR || a == twm_pkg::OFF_INT_EN;
    endfunction : addr_mapped

    // Software visible state
    twm_pkg::twm_ctrl_a_t ctrl_a_q, ctrl_a_d;
    logic [1:0] mode_high_q, mode_high_d;
    logic [15:0] buf_a_q, buf_a_d;
    logic [15:0] buf_b_q, buf_b_d;
    logic [15:0] capt_q, capt_d;
    logic [2:0] int_en_q, int_en_d;
    logic [2:0] int_st_q, int_st_d;

    // Timer state
    logic [15:0] cnt_q, cnt_d;
    logic down_q, down_d;
    logic [15:0] act_a_q, act_a_d;
    logic [15:0] act_b_q, act_b_d;
    logic wave_a_q, wave_a_d;
    logic wave_b_q, wave_b_d;

    // Bus and pin state
    logic [31:0] prdata_q, prdata_d;
    logic pready_q;
    logic pslverr_q, pslverr_d;
    logic pin_a_q, pin_a_d;
    logic pin_b_q, pin_b_d;
    logic oe_a_q, oe_b_q;
    logic irq_q, irq_d;

    // Decode helpers
    twm_pkg::twm_mode_t mode;
    logic [15:0] top_val;
    logic at_top, at_bot, at_max;
    logic hit_a, hit_b;
    logic upd_now, ovf_ev;
    logic tog_ok;
    logic [1:0] step_a, step_b;
    logic setup_ph, wr_acc;

    // Full mode from both control halves
    always_comb begin
        mode = decode_mode({mode_high_q, ctrl_a_q.waveform_mode_low});
        unique case (mode.top_src)
            twm_pkg::TS_FIXED: top_val = mode.fixed_top;
            twm_pkg::TS_CMP_A: top_val = act_a_q;
            twm_pkg::TS_CAPT: top_val = capt_q;
            default: top_val = mode.fixed_top; // Illegal source codes fall back to the fixed limit
        endcase
    end

    // Sequence points, seen only on a timer tick
    assign at_top = (cnt_q == top_val);
    assign at_bot = (cnt_q == twm_pkg::BOTTOM);
    assign at_max = (cnt_q == twm_pkg::TOP_MAX);
    assign hit_a = TIMER_TICK && (cnt_q == act_a_q);
    assign hit_b = TIMER_TICK && (cnt_q == act_b_q);

    // Compare reload and overflow point
    always_comb begin
        upd_now = (mode.upd == twm_pkg::PT_IMM)
            || (TIMER_TICK && mode.upd == twm_pkg::PT_TOP && at_top)
            || (TIMER_TICK && mode.upd == twm_pkg::PT_BOTTOM && at_bot);
        ovf_ev = TIMER_TICK && ((mode.ovf == twm_pkg::PT_MAX && at_max)
            || (mode.ovf == twm_pkg::PT_TOP && at_top)
            || (mode.ovf == twm_pkg::PT_BOTTOM && at_bot));
    end

    // In PWM modes, toggle on match is only granted to unit A, and only in a few modes
    always_comb begin
        if (mode.kind == twm_pkg::K_FAST) begin
            tog_ok = (mode_high_q == 2'b11) && ctrl_a_q.waveform_mode_low[1];
        end else begin
            tog_ok = (mode_high_q == 2'b10);
        end
        step_a = wave_step(ctrl_a_q.out_a_behaviour_field, mode.kind, tog_ok, hit_a,
            TIMER_TICK && at_top, act_a_q == top_val, down_q, wave_a_q);
        step_b = wave_step(ctrl_a_q.out_b_behaviour_field, mode.kind, 1'b0, hit_b,
            TIMER_TICK && at_top, act_b_q == top_val, down_q, wave_b_q);
    end

    // APB phases; the slave never stretches the access
    assign setup_ph = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && pready_q && PWRITE;

    // Register writes; hardware events win over a clear in the same cycle
    always_comb begin
        ctrl_a_d = ctrl_a_q;
        mode_high_d = mode_high_q;
        buf_a_d = buf_a_q;
        buf_b_d = buf_b_q;
        capt_d = capt_q;
        int_en_d = int_en_q;
        int_st_d = int_st_q;
        if (wr_acc) begin
            unique case (PADDR)
                twm_pkg::OFF_CTRL_A: begin
                    ctrl_a_d = twm_pkg::twm_ctrl_a_t'(PWDATA[7:0] & twm_pkg::CTRL_A_WMASK);
                end
                twm_pkg::OFF_CTRL_B: mode_high_d = PWDATA[1:0];
                twm_pkg::OFF_CMP_A: buf_a_d = PWDATA[15:0];
                twm_pkg::OFF_CMP_B: buf_b_d = PWDATA[15:0];
                twm_pkg::OFF_CAPT: capt_d = PWDATA[15:0];
                twm_pkg::OFF_INT_CLR: int_st_d = int_st_q & ~PWDATA[2:0];
                twm_pkg::OFF_INT_EN: int_en_d = PWDATA[2:0];
                default: ; // Status and unmapped offsets ignore writes; the count is written in the counter block
            endcase
        end
        int_st_d[twm_pkg::INT_OVF] = int_st_d[twm_pkg::INT_OVF] | ovf_ev;
        int_st_d[twm_pkg::INT_MATCH_A] = int_st_d[twm_pkg::INT_MATCH_A] | hit_a;
        int_st_d[twm_pkg::INT_MATCH_B] = int_st_d[twm_pkg::INT_MATCH_B] | hit_b;
    end

    // Counter sequence; a software write to the count wins over a tick
    always_comb begin
        cnt_d = cnt_q;
        down_d = down_q;
        if (wr_acc && PADDR == twm_pkg::OFF_COUNT) begin
            cnt_d = PWDATA[15:0];
        end else if (TIMER_TICK) begin
            if (mode.kind == twm_pkg::K_PC || mode.kind == twm_pkg::K_PFC) begin
                if (!down_q) begin
                    down_d = at_top;
                    cnt_d = at_top ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
                end else begin
                    down_d = !at_bot;
                    cnt_d = at_bot ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
                end
            end else if (mode.kind != twm_pkg::K_RSVD) begin
                down_d = 1'b0;
                cnt_d = at_top ? twm_pkg::BOTTOM : cnt_q + 16'h0001;
            end
        end
    end

    // Double-buffered compares and waveform bits
    always_comb begin
        act_a_d = upd_now ? buf_a_q : act_a_q;
        act_b_d = upd_now ? buf_b_q : act_b_q;
        wave_a_d = step_a[0];
        wave_b_d = step_b[0];
    end

    // Pin mux and interrupt request; port value passes when disconnected
    always_comb begin
        pin_a_d = step_a[1] ? step_a[0] : PORT_A;
        pin_b_d = step_b[1] ? step_b[0] : PORT_B;
        irq_d = |(int_st_d & int_en_d);
    end

    // Read data is latched in the setup cycle so it stands in the access cycle
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup_ph) begin
            pslverr_d = !addr_mapped(PADDR);
            unique case (PADDR)
                twm_pkg::OFF_CTRL_A: prdata_d = {24'h000000, ctrl_a_q};
                twm_pkg::OFF_CTRL_B: prdata_d = {30'h0, mode_high_q};
                twm_pkg::OFF_CMP_A: prdata_d = {16'h0000, buf_a_q};
                twm_pkg::OFF_CMP_B: prdata_d = {16'h0000, buf_b_q};
                twm_pkg::OFF_CAPT: prdata_d = {16'h0000, capt_q};
                twm_pkg::OFF_COUNT: prdata_d = {16'h0000, cnt_q};
                twm_pkg::OFF_INT_STAT: prdata_d = {29'h0, int_st_q};
                twm_pkg::OFF_INT_EN: prdata_d = {29'h0, int_en_q};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_a_q <= twm_pkg::twm_ctrl_a_t'(twm_pkg::CTRL_A_RESET);
            mode_high_q <= twm_pkg::CTRL_B_RESET;
            buf_a_q <= twm_pkg::WORD_RESET;
            buf_b_q <= twm_pkg::WORD_RESET;
            capt_q <= twm_pkg::WORD_RESET;
            int_en_q <= twm_pkg::INT_RESET;
            int_st_q <= twm_pkg::INT_RESET;
            cnt_q <= twm_pkg::WORD_RESET;
            down_q <= 1'b0;
            act_a_q <= twm_pkg::WORD_RESET;
            act_b_q <= twm_pkg::WORD_RESET;
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            oe_a_q <= 1'b0;
            oe_b_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_a_q <= ctrl_a_d;
            mode_high_q <= mode_high_d;
            buf_a_q <= buf_a_d;
            buf_b_q <= buf_b_d;
            capt_q <= capt_d;
            int_en_q <= int_en_d;
            int_st_q <= int_st_d;
            cnt_q <= cnt_d;
            down_q <= down_d;
            act_a_q <= act_a_d;
            act_b_q <= act_b_d;
            wave_a_q <= wave_a_d;
            wave_b_q <= wave_b_d;
            prdata_q <= prdata_d;
            pready_q <= 1'b1;
            pslverr_q <= pslverr_d;
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
            oe_a_q <= DIR_A;
            oe_b_q <= DIR_B;
            irq_q <= irq_d;
        end
    end

    // Outputs straight from flops
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PIN_A_OUT = pin_a_q;
    assign PIN_A_OE = oe_a_q;
    assign PIN_B_OUT = pin_b_q;
    assign PIN_B_OE = oe_b_q;
    assign IRQ = irq_q;

endmodule : twm_timer_top
